// ===== logic/dbx_regs.vh
// register indices, field positions, reset values and vectors of the debug exception logic
`ifndef DBX_REGS_VH
`define DBX_REGS_VH
// ****************************************
// register select codes
// ****************************************
`define DBX_SEL_BKPT0 3'h0
`define DBX_SEL_BKPT1 3'h1
`define DBX_SEL_BKPT2 3'h2
`define DBX_SEL_BKPT3 3'h3
`define DBX_SEL_STATUS 3'h6
`define DBX_SEL_CONTROL 3'h7
// ****************************************
// field positions
// ****************************************
`define DBX_ST_DETECT 13
`define DBX_ST_STEP 14
`define DBX_ST_TASK 15
`define DBX_CT_DETECT_EN 13
`define DBX_CT_TYPE_BASE 16
// ****************************************
// reset values, reserved bit masks
// ****************************************
`define DBX_STATUS_RST 64'h0000_0000_ffff_0ff0
`define DBX_CONTROL_RST 64'h0000_0000_0000_0400
`define DBX_STATUS_FIXED1 64'h0000_0000_ffff_0ff0
`define DBX_CONTROL_FIXED1 64'h0000_0000_0000_0400
`define DBX_UPPER_MASK 64'hffff_ffff_0000_0000
// ****************************************
// breakpoint type and length codes
// ****************************************
`define DBX_TYPE_EXEC 2'h0
`define DBX_TYPE_WRITE 2'h1
`define DBX_TYPE_IO 2'h2
`define DBX_TYPE_RDWR 2'h3
`define DBX_LEN_1 2'h0
`define DBX_LEN_2 2'h1
`define DBX_LEN_8 2'h2
`define DBX_LEN_4 2'h3
// ****************************************
// vectors and access kinds
// ****************************************
`define DBX_VEC_DEBUG 8'h01
`define DBX_VEC_SWBP 8'h03
`define DBX_ACC_READ 2'h0
`define DBX_ACC_WRITE 2'h1
`define DBX_ACC_IO 2'h2
`endif

// ===== logic/dbx_debug_exception_logic.v
// debug exception logic: debug registers, breakpoint match, resume flag
`timescale 1ns/100ps
`include "dbx_regs.vh"
module dbx_debug_exception_logic #(
  parameter ADDR_W = 64
) (
  input wire i_clock,
  input wire i_rst_n,
  // register move port
  input wire i_mode64,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [2:0] i_reg_sel,
  input wire [63:0] i_reg_wdata,
  input wire i_cpl0,
  input wire i_debug_ext_en,
  // instruction start
  input wire i_insn_start,
  input wire [ADDR_W-1:0] i_insn_addr,
  input wire i_insn_other_fault,
  input wire i_insn_is_dbgmov,
  input wire i_prev_stack_load,
  // data / io access
  input wire i_acc_valid,
  input wire [1:0] i_acc_kind,
  input wire [ADDR_W-1:0] i_acc_addr,
  input wire [3:0] i_acc_len,
  // instruction end
  input wire i_insn_done,
  input wire i_single_step,
  input wire i_task_switch,
  input wire i_task_trap_bit,
  input wire i_debug_trap_insn,
  input wire i_swbp_insn,
  // resume flag sources
  input wire i_wide_narrow_interrupt_return,
  input wire i_narrow_narrow_interrupt_return,
  input wire i_flag_pop,
  input wire i_resume_image,
  // event delivery
  input wire i_deliver,
  input wire i_deliver_fault,
  input wire i_deliver_ibp,
  input wire i_deliver_mid_string,
  input wire i_deliver_soft_int,
  input wire i_dbx_taken,
  // outputs
  output reg [63:0] o_reg_rdata,
  output reg o_reg_rvalid,
  output reg o_gp_fault,
  output reg o_dbx_req,
  output reg o_dbx_fault,
  output reg [63:0] o_dbx_status,
  output reg [7:0] o_dbx_vector,
  output reg o_swbp_req,
  output reg [7:0] o_swbp_vector,
  output reg o_insn_hold,
  output reg o_resume_flag,
  output reg o_pushed_resume
);
  // ****************************************
  // state
  // ****************************************
  reg [63:0] bkpt_q [0:3];
  reg [63:0] status_q;
  reg [63:0] control_q;
  reg resume_q;
  reg resume_d;
  reg [63:0] wdata;
  reg upper_bad;
  reg gp_d;
  wire [3:0] exec_hit;
  wire [3:0] data_hit;
  wire [3:0] bp_en;
  wire [ADDR_W-1:0] acc_last;
  reg ibp_ok;
  reg fault_ev;
  reg trap_ev;
  reg [63:0] st_d;
  reg [63:0] ct_d;
  reg [3:0] hit_sum;
  integer k;
  integer j;
  reg wr_ok;
  reg [63:0] rd_sel;
  reg [63:0] rdata_d;
  reg [63:0] status_d;
  reg [63:0] control_d;
  reg rvalid_d;
  reg push_d;

  assign acc_last = i_acc_addr + {{(ADDR_W-4){1'b0}}, i_acc_len} -
                    {{(ADDR_W-1){1'b0}}, 1'b1};
  // ****************************************
  // breakpoint decode per slot
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_bp
      wire [1:0] tcode;
      wire [1:0] lcode;
      wire [ADDR_W-1:0] mask;
      wire [ADDR_W-1:0] lo;
      wire [ADDR_W-1:0] hi;
      wire kind_ok;
      assign bp_en[g] = control_q[2*g] | control_q[2*g+1];
      assign tcode = control_q[`DBX_CT_TYPE_BASE+4*g +: 2];
      assign lcode = control_q[`DBX_CT_TYPE_BASE+4*g+2 +: 2];
      // range size from length code, low bits masked
      assign mask = (lcode == `DBX_LEN_2) ? {{(ADDR_W-1){1'b1}}, 1'b0} :
                    (lcode == `DBX_LEN_4) ? {{(ADDR_W-2){1'b1}}, 2'b00} :
                    (lcode == `DBX_LEN_8) ? {{(ADDR_W-3){1'b1}}, 3'b000} :
                    {ADDR_W{1'b1}};
      assign lo = bkpt_q[g][ADDR_W-1:0] & mask;
      assign hi = lo | ~mask;
      assign kind_ok =
        (tcode == `DBX_TYPE_WRITE && i_acc_kind == `DBX_ACC_WRITE) ||
        (tcode == `DBX_TYPE_RDWR && i_acc_kind != `DBX_ACC_IO) ||
        (tcode == `DBX_TYPE_IO && i_debug_ext_en &&
         i_acc_kind == `DBX_ACC_IO);
      assign exec_hit[g] = bp_en[g] && tcode == `DBX_TYPE_EXEC &&
        i_insn_addr == bkpt_q[g][ADDR_W-1:0];
      assign data_hit[g] = bp_en[g] && i_acc_valid && kind_ok &&
        i_acc_addr <= hi && acc_last >= lo;
    end
  endgenerate

  // ****************************************
  // register write path and fault checks
  // ****************************************
  always @* begin
    wdata = i_mode64 ? i_reg_wdata :
            {32'h0000_0000, i_reg_wdata[31:0]};
    upper_bad = i_mode64 && (i_reg_sel == `DBX_SEL_STATUS ||
                i_reg_sel == `DBX_SEL_CONTROL) &&
                |(i_reg_wdata & `DBX_UPPER_MASK);
    gp_d = i_reg_wr && upper_bad;
  end

  // ****************************************
  // event classification
  // ****************************************
  always @* begin
    ibp_ok = i_insn_start && |exec_hit && !resume_q &&
             !i_prev_stack_load;
    fault_ev = ibp_ok || (i_insn_start && i_insn_is_dbgmov &&
               control_q[`DBX_CT_DETECT_EN]);
    trap_ev = i_insn_done && (i_single_step ||
              (i_task_switch && i_task_trap_bit) ||
              i_debug_trap_insn || |data_hit);
    hit_sum = 4'h0;
    for (k = 0; k < 4; k = k + 1) begin
      if (ibp_ok && exec_hit[k]) begin
        hit_sum[k] = 1'b1;
      end
      if (i_insn_done && data_hit[k]) begin
        hit_sum[k] = 1'b1;
      end
    end
    st_d = status_q;
    if (fault_ev || trap_ev) begin
      st_d[3:0] = hit_sum;
      st_d[`DBX_ST_DETECT] = fault_ev && !ibp_ok;
      st_d[`DBX_ST_STEP] = trap_ev && i_single_step;
      st_d[`DBX_ST_TASK] = trap_ev && i_task_switch && i_task_trap_bit;
    end
    ct_d = control_q;
    if (i_dbx_taken) begin
      ct_d[`DBX_CT_DETECT_EN] = 1'b0;
    end
  end

  // ****************************************
  // resume flag
  // ****************************************
  always @* begin
    resume_d = resume_q;
    if (i_insn_start) begin
      resume_d = 1'b0;
    end
    if (i_task_switch || i_wide_narrow_interrupt_return) begin
      resume_d = i_resume_image;
    end
    if (i_flag_pop || i_narrow_narrow_interrupt_return) begin
      resume_d = resume_d;
    end
  end

  // ****************************************
  // register write decode
  // ****************************************
  // a faulting move or a reserved-bit write is dropped; event updates of status and control still apply
  always @* begin
    wr_ok = i_reg_wr && !gp_d && !fault_ev;
    status_d = st_d | `DBX_STATUS_FIXED1;
    control_d = ct_d;
    if (wr_ok && i_reg_sel == `DBX_SEL_STATUS) begin
      // software write wins over a same-cycle event update
      status_d = wdata | `DBX_STATUS_FIXED1;
    end
    if (wr_ok && i_reg_sel == `DBX_SEL_CONTROL) begin
      control_d = wdata | `DBX_CONTROL_FIXED1;
    end
  end

  // ****************************************
  // register read mux
  // ****************************************
  always @* begin
    case (i_reg_sel)
      `DBX_SEL_BKPT0: begin
        rd_sel = bkpt_q[0];
      end
      `DBX_SEL_BKPT1: begin
        rd_sel = bkpt_q[1];
      end
      `DBX_SEL_BKPT2: begin
        rd_sel = bkpt_q[2];
      end
      `DBX_SEL_BKPT3: begin
        rd_sel = bkpt_q[3];
      end
      `DBX_SEL_STATUS: begin
        rd_sel = status_q;
      end
      `DBX_SEL_CONTROL: begin
        rd_sel = control_q;
      end
      // unused select codes read as zero
      default: begin
        rd_sel = 64'h0000_0000_0000_0000;
      end
    endcase
    // read data holds between reads
    rdata_d = o_reg_rdata;
    if (i_reg_rd) begin
      if (i_mode64) begin
        rdata_d = rd_sel;
      end else begin
        rdata_d = {32'h0000_0000, rd_sel[31:0]};
      end
    end
    rvalid_d = i_reg_rd && !fault_ev;
  end

  // ****************************************
  // pushed resume flag
  // ****************************************
  // non-breakpoint fault first, then mid-string, then soft interrupt, then the live flag
  always @* begin
    push_d = o_pushed_resume;
    if (i_deliver) begin
      if (i_deliver_fault && !i_deliver_ibp) begin
        push_d = 1'b1;
      end else if (i_deliver_mid_string) begin
        push_d = 1'b1;
      end else if (i_deliver_soft_int) begin
        push_d = 1'b0;
      end else begin
        push_d = resume_q;
      end
    end
  end

  // ****************************************
  // debug register state
  // ****************************************
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      for (j = 0; j < 4; j = j + 1) begin
        bkpt_q[j] <= 64'h0000_0000_0000_0000;
      end
      // no enables and no flags, so no breakpoint or general detect fires straight after reset
      status_q <= `DBX_STATUS_RST;
      control_q <= `DBX_CONTROL_RST;
      resume_q <= 1'b0;
    end else begin
      // address registers take every bit, no range check
      if (wr_ok && i_reg_sel == `DBX_SEL_BKPT0) begin
        bkpt_q[0] <= wdata;
      end
      if (wr_ok && i_reg_sel == `DBX_SEL_BKPT1) begin
        bkpt_q[1] <= wdata;
      end
      if (wr_ok && i_reg_sel == `DBX_SEL_BKPT2) begin
        bkpt_q[2] <= wdata;
      end
      if (wr_ok && i_reg_sel == `DBX_SEL_BKPT3) begin
        bkpt_q[3] <= wdata;
      end
      status_q <= status_d;
      control_q <= control_d;
      resume_q <= resume_d;
    end
  end

  // ****************************************
  // register port outputs
  // ****************************************
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 64'h0000_0000_0000_0000;
      o_reg_rvalid <= 1'b0;
      o_gp_fault <= 1'b0;
    end else begin
      o_reg_rdata <= rdata_d;
      o_reg_rvalid <= rvalid_d;
      o_gp_fault <= gp_d;
    end
  end

  // ****************************************
  // exception request outputs
  // ****************************************
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_dbx_req <= 1'b0;
      o_dbx_fault <= 1'b0;
      o_dbx_status <= 64'h0000_0000_0000_0000;
      o_dbx_vector <= `DBX_VEC_DEBUG;
      o_swbp_req <= 1'b0;
      o_swbp_vector <= `DBX_VEC_SWBP;
      o_insn_hold <= 1'b0;
    end else begin
      // one request, fault before the instruction, trap after
      o_dbx_req <= fault_ev || trap_ev;
      o_dbx_fault <= fault_ev;
      o_dbx_status <= st_d | `DBX_STATUS_FIXED1;
      // vectors are fixed but kept as plain flops like every output
      o_dbx_vector <= `DBX_VEC_DEBUG;
      o_swbp_req <= i_insn_done && i_swbp_insn;
      o_swbp_vector <= `DBX_VEC_SWBP;
      o_insn_hold <= ibp_ok;
    end
  end

  // ****************************************
  // resume flag outputs
  // ****************************************
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_resume_flag <= 1'b0;
      o_pushed_resume <= 1'b0;
    end else begin
      o_resume_flag <= resume_d;
      o_pushed_resume <= push_d;
    end
  end
endmodule // dbx_debug_exception_logic

// ===== tb/dbx_debug_exception_logic_asserts.sv
// port assertions for the debug exception logic
`timescale 1ns/100ps
module dbx_debug_exception_logic_asserts (
  input wire i_clock,
  input wire i_rst_n,
  input wire i_mode64,
  input wire i_reg_wr,
  input wire [2:0] i_reg_sel,
  input wire [63:0] i_reg_wdata,
  input wire i_insn_start,
  input wire i_insn_done,
  input wire i_single_step,
  input wire i_acc_valid,
  input wire i_debug_trap_insn,
  input wire i_task_switch,
  input wire i_wide_narrow_interrupt_return,
  input wire i_resume_image,
  input wire i_deliver,
  input wire i_deliver_fault,
  input wire i_deliver_ibp,
  input wire i_deliver_mid_string,
  input wire o_reg_rvalid,
  input wire [63:0] o_reg_rdata,
  input wire o_gp_fault,
  input wire o_dbx_req,
  input wire o_dbx_fault,
  input wire [63:0] o_dbx_status,
  input wire [7:0] o_dbx_vector,
  input wire [7:0] o_swbp_vector,
  input wire o_resume_flag,
  input wire o_pushed_resume
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  sequence s_quiet_end;
    i_insn_done && !i_insn_start && !i_acc_valid && !i_task_switch;
  endsequence
  sequence s_trap_taken;
    o_dbx_req && !o_dbx_fault;
  endsequence
  a_debug_vectors:
    assert property (o_dbx_vector == 8'h01 && o_swbp_vector == 8'h03)
    else $error("vector code wrong");
  a_gp_upper:
    assert property (i_reg_wr && i_mode64 && i_reg_sel[2:1] == 2'b11 &&
      |i_reg_wdata[63:32] |=> o_gp_fault) else $error("no gp fault");
  a_legacy_read:
    assert property (o_reg_rvalid && !$past(i_mode64) |->
      o_reg_rdata[63:32] == 32'h0) else $error("upper half on read");
  a_step_trap:
    assert property (s_quiet_end ##0 i_single_step |=>
      s_trap_taken ##0 o_dbx_status[14]) else $error("step trap wrong");
  a_debug_trap_instruction_trap:
    assert property (s_quiet_end ##0 i_debug_trap_insn && !i_single_step
      |=> s_trap_taken ##0 o_dbx_status[15:13] == 3'h0)
    else $error("debug trap insn wrong");
  a_resume_load:
    assert property (i_wide_narrow_interrupt_return |=> o_resume_flag == $past(i_resume_image))
    else $error("resume not loaded");
  a_fault_push:
    assert property (i_deliver && i_deliver_fault && !i_deliver_ibp |=>
      o_pushed_resume) else $error("fault pushed resume 0");
  a_string_push:
    assert property (i_deliver && i_deliver_mid_string && !i_deliver_ibp
      |=> o_pushed_resume) else $error("string pushed resume 0");
endmodule // dbx_debug_exception_logic_asserts
bind dbx_debug_exception_logic dbx_debug_exception_logic_asserts i_chk (.*);

// ===== tb/dbx_pipe_model.sv
// pipeline model: handler return, then restart twice at one address
`timescale 1ns/100ps
module dbx_pipe_model (
  input wire i_clock,
  input wire i_go,
  input wire [63:0] i_addr,
  output logic o_wide_narrow_interrupt_return,
  output logic o_resume_image,
  output logic o_insn_start,
  output logic [63:0] o_insn_addr
);
  initial begin
    {o_wide_narrow_interrupt_return, o_resume_image, o_insn_start} = 3'h0;
    o_insn_addr = 64'h0;
    forever begin
      @(posedge i_clock);
      if (i_go) begin
        #1 o_wide_narrow_interrupt_return = 1'b1;
        o_resume_image = 1'b1;
        @(posedge i_clock);
        #1 o_wide_narrow_interrupt_return = 1'b0;
        o_resume_image = 1'b0;
        o_insn_start = 1'b1;
        o_insn_addr = i_addr;
        repeat (2) @(posedge i_clock);
        #1 o_insn_start = 1'b0;
        o_insn_addr = ~i_addr;
      end
    end
  end
endmodule // dbx_pipe_model

// ===== tb/dbx_debug_exception_logic_tb.sv
// self-checking bench of the debug exception logic
`timescale 1ns/100ps
`include "dbx_regs.vh"
module dbx_debug_exception_logic_tb;
  logic i_clock, i_rst_n, i_mode64, i_reg_wr, i_reg_rd, go, rnd;
  logic [2:0] i_reg_sel;
  logic [63:0] i_reg_wdata, i_insn_addr, i_acc_addr, a, b;
  logic [1:0] i_acc_kind;
  logic [3:0] i_acc_len;
  logic i_insn_start, i_insn_other_fault, i_insn_is_dbgmov, i_prev_stack_load;
  logic i_acc_valid, i_insn_done, i_single_step, i_task_switch;
  logic i_task_trap_bit, i_debug_trap_insn, i_swbp_insn, i_wide_narrow_interrupt_return;
  logic i_narrow_narrow_interrupt_return, i_flag_pop, i_resume_image, i_deliver, i_dbx_taken;
  logic i_deliver_fault, i_deliver_ibp, i_deliver_mid_string;
  logic i_deliver_soft_int, m_narrow_interrupt_return, m_img, m_start;
  logic [63:0] m_iaddr, o_reg_rdata, o_dbx_status;
  logic [7:0] o_dbx_vector, o_swbp_vector;
  logic o_reg_rvalid, o_gp_fault, o_dbx_req, o_dbx_fault, o_swbp_req;
  logic o_insn_hold, o_resume_flag, o_pushed_resume;
  int fails, num_checks;
  dbx_debug_exception_logic i_dbx_debug_exception_logic (.*,
    .i_cpl0(1'b0), .i_debug_ext_en(1'b1),
    .i_insn_start(i_insn_start | m_start),
    .i_insn_addr(m_start ? m_iaddr : i_insn_addr),
    .i_wide_narrow_interrupt_return(i_wide_narrow_interrupt_return | m_narrow_interrupt_return),
    .i_resume_image(m_narrow_interrupt_return ? m_img : i_resume_image));
  dbx_pipe_model i_dbx_pipe_model (.i_clock(i_clock), .i_go(go),
    .i_addr(a), .o_wide_narrow_interrupt_return(m_narrow_interrupt_return), .o_resume_image(m_img),
    .o_insn_start(m_start), .o_insn_addr(m_iaddr));
  // ****
  // tasks
  // ****
  task automatic nx();
    @(posedge i_clock);
    #1;
  endtask
  task automatic clr();
    {go, i_reg_wr, i_reg_rd} = 3'h0;
    {i_insn_start, i_insn_other_fault, i_insn_is_dbgmov, i_prev_stack_load,
     i_acc_valid, i_insn_done, i_single_step, i_task_switch, i_task_trap_bit,
     i_debug_trap_insn, i_swbp_insn, i_wide_narrow_interrupt_return, i_narrow_narrow_interrupt_return, i_flag_pop,
     i_resume_image, i_deliver, i_deliver_fault, i_deliver_ibp,
     i_deliver_mid_string, i_deliver_soft_int, i_dbx_taken} =
      rnd ? 21'($urandom) : 21'h0;
  endtask
  task automatic tick();
    nx();
    clr();
  endtask
  task automatic rop(input m, w, input [2:0] s, input [63:0] d);
    nx();
    i_mode64 = m;
    i_reg_wr = w;
    i_reg_rd = !w;
    i_reg_sel = s;
    i_reg_wdata = d;
    tick();
  endtask
  task automatic chk(input string n, input logic [63:0] e, g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  function automatic [2:0] flg(input int i);
    return i == 0 ? 3'b010 : i == 1 ? 3'b000 : 3'b100;
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    i_clock = 0;
    forever #12.5 i_clock = ~i_clock;
  end
  initial begin
    #50000;
    fails++;
    summarize();
  end
  // ****
  // tests
  // ****
  initial begin
    {i_rst_n, i_mode64, rnd, i_reg_sel, i_reg_wdata, i_insn_addr} = 0;
    {i_acc_addr, i_acc_kind, i_acc_len, fails, num_checks} = 0;
    clr();
    void'($urandom(32'hfe80));
    repeat (2) @(posedge i_clock);
    #1 i_rst_n = 1;
    for (int s = 6; s < 8; s++) begin
      b = s == 6 ? `DBX_STATUS_RST : `DBX_CONTROL_RST;
      rop(1, 0, 3'(s), 0);
      chk("rst", b, o_reg_rdata);
      rop(1, 1, 3'(s), b | 64'h1_0000_0000);
      chk("gp", 1, o_gp_fault);
      rop(1, 0, 3'(s), 0);
      chk("kept", b, o_reg_rdata);
    end
    for (int n = 0; n < 4; n++) begin
      a = {$urandom, $urandom};
      rop(1, 1, 3'(n), a);
      rop(1, 0, 3'(n), 0);
      chk("full", a, o_reg_rdata);
      rop(0, 1, 3'(n), a);
      rop(0, 0, 3'(n), 0);
      chk("low", {32'h0, a[31:0]}, o_reg_rdata);
    end
    $display("register test done");
    rop(1, 1, 0, a);
    rop(1, 1, 7, 64'h401);
    nx();
    {i_insn_start, i_insn_other_fault, i_insn_addr} = {2'b11, a};
    tick();
    chk("ibp", 3'b111, {o_dbx_req, o_dbx_fault, o_insn_hold});
    chk("hit0", 1, o_dbx_status[0]);
    nx();
    {i_insn_start, i_prev_stack_load} = 2'b11;
    tick();
    chk("ssload", 0, o_dbx_req);
    nx();
    go = 1;
    tick();
    nx();
    chk("rf_load", 1, o_resume_flag);
    nx();
    chk("rf_mask", 2'b00, {o_dbx_req, o_resume_flag});
    nx();
    chk("rf_once", 2'b11, {o_dbx_req, o_dbx_fault});
    $display("instruction breakpoint test done");
    b = {$urandom, $urandom} & ~64'h7 | 64'h8;
    rop(1, 1, 1, b);
    rop(1, 1, 7, 64'h00b0_0004);
    for (int k = 0; k < 3; k++) begin
      nx();
      {i_acc_valid, i_insn_done, i_acc_kind} = {2'b11, 2'(k % 2)};
      i_acc_addr = b + 64'(k == 0 ? -1 : k == 1 ? 7 : 8);
      i_acc_len = k == 0 ? 4'h2 : 4'h1;
      tick();
      chk("dcls", k < 2 ? 2'b10 : 2'b00, {o_dbx_req, o_dbx_fault});
      if (k < 2) chk("hit1", 1, o_dbx_status[1]);
    end
    for (int i = 0; i < 3; i++) begin
      nx();
      {i_task_switch, i_debug_trap_insn, i_single_step} = 3'b001 << i;
      {i_insn_done, i_task_trap_bit} = {1'b1, i == 2};
      tick();
      chk("ecls", 2'b10, {o_dbx_req, o_dbx_fault});
      chk("eflg", flg(i), o_dbx_status[15:13]);
    end
    nx();
    {i_insn_done, i_swbp_insn} = 2'b11;
    tick();
    chk("swbp", 1, o_swbp_req);
    for (int i = 0; i < 3; i++) begin
      nx();
      i_deliver = 1;
      {i_deliver_fault, i_deliver_mid_string, i_deliver_soft_int} = 3'd4 >> i;
      tick();
      chk("push", i < 2, o_pushed_resume);
    end
    rop(1, 1, 7, 64'h2400);
    nx();
    {i_insn_start, i_insn_is_dbgmov} = 2'b11;
    tick();
    chk("gd", 2'b11, {o_dbx_req, o_dbx_fault});
    chk("gflg", 3'b001, o_dbx_status[15:13]);
    nx();
    i_dbx_taken = 1;
    tick();
    rop(1, 0, 7, 0);
    chk("gclr", 64'h400, o_reg_rdata);
    $display("event test done");
    rnd = 1;
    repeat (300) tick();
    rnd = 0;
    tick();
    $display("random test done");
    summarize();
  end
endmodule // dbx_debug_exception_logic_tb
